// ==== rtl/ssm_pkg.sv ====
// Constants, types and register layout of the modem mode and carrier register bank.
// Assumes one clock domain and a host that issues one-cycle register strobes.
package ssm_pkg;

	// Register offsets
	localparam logic [6:0] FIFO_PORT_ADDR = 7'h00;
	localparam logic [6:0] OP_MODE_ADDR = 7'h01;
	localparam logic [6:0] RSVD_02_ADDR = 7'h02;
	localparam logic [6:0] RSVD_03_ADDR = 7'h03;
	localparam logic [6:0] RSVD_04_ADDR = 7'h04;
	localparam logic [6:0] RSVD_05_ADDR = 7'h05;
	localparam logic [6:0] FREQ_HIGH_ADDR = 7'h06;
	localparam logic [6:0] FREQ_MID_ADDR = 7'h07;
	localparam logic [6:0] FREQ_LOW_ADDR = 7'h08;
	localparam logic [6:0] PAGE_FIRST_ADDR = 7'h0D;
	localparam logic [6:0] PAGE_LAST_ADDR = 7'h3F;
	localparam logic [6:0] BAND_FIRST_ADDR = 7'h61;
	localparam logic [6:0] BAND_LAST_ADDR = 7'h73;
	localparam int PAGE_DEPTH = 51;
	localparam int BAND_DEPTH = 19;

	// Operating mode field positions
	localparam int FAMILY_BIT = 7;
	localparam int SHARED_BIT = 6;
	localparam int RSVD_HI_BIT = 5;
	localparam int RSVD_LO_BIT = 4;
	localparam int BAND_BIT = 3;
	localparam int STATE_HI_BIT = 2;

	// Reset values
	localparam logic [7:0] OP_MODE_RESET = 8'h09;
	localparam logic [7:0] FREQ_HIGH_RESET = 8'h6C;
	localparam logic [7:0] FREQ_MID_RESET = 8'h80;
	localparam logic [7:0] FREQ_LOW_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// Carrier step: crystal times word over two to the nineteenth
	localparam int FREQ_SHIFT = 19;
	localparam real XTAL_MHZ = 32.0;

	// Device state codes, fixed by the register encoding
	typedef enum logic [2:0] {
		ST_SLEEP = 3'h0,
		ST_STANDBY = 3'h1,
		ST_TX_SYNTH = 3'h2,
		ST_TRANSMIT = 3'h3,
		ST_RX_SYNTH = 3'h4,
		ST_RX_CONT = 3'h5,
		ST_RX_SINGLE = 3'h6,
		ST_ACT_DETECT = 3'h7
	} ssm_state_t;

	// Host register request
	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ssm_req_t;

	// Base-band FIFO port toward the data path
	typedef struct packed {
		logic push;
		logic pop;
		logic clear;
		logic [7:0] wdata;
	} ssm_fifo_t;

endpackage : ssm_pkg

// ==== rtl/ssm_regs.sv ====
// Register bank of the spread-spectrum modem: FIFO port, operating mode, carrier word,
// two modem pages and two band banks. Assumes a same-clock host and FIFO data path.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps

module ssm_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Host register port
	input ssm_pkg::ssm_req_t bus_req,
	output logic [7:0] bus_rdata,
	// Base-band FIFO
	output ssm_pkg::ssm_fifo_t fifo_ctl,
	input wire logic [7:0] fifo_head,
	// Mode and carrier
	output ssm_pkg::ssm_state_t dev_state,
	output logic modem_family_select,
	output logic band_bank_select,
	output logic mode_trigger,
	output logic freq_trigger,
	output logic [23:0] carrier_word
);

	logic [7:0] op_mode_reg;
	logic [7:0] freq_high_reg;
	logic [7:0] freq_mid_reg;
	logic [7:0] freq_low_reg;
	logic [7:0] rsvd_04_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic fifo_push_reg;
	logic fifo_pop_reg;
	logic fifo_clear_reg;
	logic [7:0] fifo_wdata_reg;
	logic mode_trig_reg;
	logic freq_trig_reg;
	logic [7:0] page_mem [2][ssm_pkg::PAGE_DEPTH];
	logic [7:0] band_mem [2][ssm_pkg::BAND_DEPTH];

	logic asleep;
	logic in_page;
	logic in_band;
	logic page_sel;
	logic [6:0] page_off;
	logic [6:0] band_off;
	logic [5:0] page_idx;
	logic [4:0] band_idx;

	assign asleep = op_mode_reg[ssm_pkg::STATE_HI_BIT:0] == ssm_pkg::ST_SLEEP;
	assign in_page = bus_req.addr >= ssm_pkg::PAGE_FIRST_ADDR
		&& bus_req.addr <= ssm_pkg::PAGE_LAST_ADDR;
	assign in_band = bus_req.addr >= ssm_pkg::BAND_FIRST_ADDR
		&& bus_req.addr <= ssm_pkg::BAND_LAST_ADDR;
	assign page_off = bus_req.addr - ssm_pkg::PAGE_FIRST_ADDR;
	assign band_off = bus_req.addr - ssm_pkg::BAND_FIRST_ADDR;
	assign page_idx = page_off[5:0];
	assign band_idx = band_off[4:0];

	// page routing: 1 is the spread-spectrum page
	assign page_sel = op_mode_reg[ssm_pkg::FAMILY_BIT] & ~op_mode_reg[ssm_pkg::SHARED_BIT];

	// Operating mode register
	always_ff @(posedge clk) begin
		if (rst) begin
			op_mode_reg <= ssm_pkg::OP_MODE_RESET;
		end else if (bus_req.wr && bus_req.addr == ssm_pkg::OP_MODE_ADDR) begin
			if (asleep) begin
				op_mode_reg[ssm_pkg::FAMILY_BIT] <= bus_req.wdata[ssm_pkg::FAMILY_BIT];
			end
			op_mode_reg[ssm_pkg::SHARED_BIT] <= bus_req.wdata[ssm_pkg::SHARED_BIT];
			op_mode_reg[ssm_pkg::BAND_BIT] <= bus_req.wdata[ssm_pkg::BAND_BIT];
			op_mode_reg[ssm_pkg::RSVD_HI_BIT:ssm_pkg::RSVD_LO_BIT] <= 2'h0;
			op_mode_reg[ssm_pkg::STATE_HI_BIT:0] <= bus_req.wdata[ssm_pkg::STATE_HI_BIT:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mode_trig_reg <= 1'b0;
		end else begin
			mode_trig_reg <= bus_req.wr && bus_req.addr == ssm_pkg::OP_MODE_ADDR;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			freq_high_reg <= ssm_pkg::FREQ_HIGH_RESET;
			freq_mid_reg <= ssm_pkg::FREQ_MID_RESET;
			freq_low_reg <= ssm_pkg::FREQ_LOW_RESET;
		end else if (bus_req.wr) begin
			if (bus_req.addr == ssm_pkg::FREQ_HIGH_ADDR) begin
				freq_high_reg <= bus_req.wdata;
			end
			if (bus_req.addr == ssm_pkg::FREQ_MID_ADDR) begin
				freq_mid_reg <= bus_req.wdata;
			end
			if (bus_req.addr == ssm_pkg::FREQ_LOW_ADDR) begin
				freq_low_reg <= bus_req.wdata;
			end
		end
	end

	// low byte write retunes; host keeps it to sleep or standby
	always_ff @(posedge clk) begin
		if (rst) begin
			freq_trig_reg <= 1'b0;
		end else begin
			freq_trig_reg <= bus_req.wr && bus_req.addr == ssm_pkg::FREQ_LOW_ADDR;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rsvd_04_reg <= ssm_pkg::BYTE_RESET;
		end else if (bus_req.wr && bus_req.addr == ssm_pkg::RSVD_04_ADDR) begin
			rsvd_04_reg <= bus_req.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int p = 0; p < 2; p++) begin
				for (int i = 0; i < ssm_pkg::PAGE_DEPTH; i++) begin
					page_mem[p][i] <= ssm_pkg::BYTE_RESET;
				end
			end
		end else if (bus_req.wr && in_page) begin
			page_mem[page_sel][page_idx] <= bus_req.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int b = 0; b < 2; b++) begin
				for (int i = 0; i < ssm_pkg::BAND_DEPTH; i++) begin
					band_mem[b][i] <= ssm_pkg::BYTE_RESET;
				end
			end
		end else if (bus_req.wr && in_band) begin
			band_mem[op_mode_reg[ssm_pkg::BAND_BIT]][band_idx] <= bus_req.wdata;
		end
	end

	// FIFO port, closed and cleared in sleep
	always_ff @(posedge clk) begin
		if (rst) begin
			fifo_push_reg <= 1'b0;
			fifo_pop_reg <= 1'b0;
			fifo_clear_reg <= 1'b0;
			fifo_wdata_reg <= ssm_pkg::BYTE_RESET;
		end else begin
			fifo_push_reg <= bus_req.wr && bus_req.addr == ssm_pkg::FIFO_PORT_ADDR && !asleep;
			fifo_pop_reg <= bus_req.rd && bus_req.addr == ssm_pkg::FIFO_PORT_ADDR && !asleep;
			fifo_clear_reg <= asleep;
			if (bus_req.wr && bus_req.addr == ssm_pkg::FIFO_PORT_ADDR) begin
				fifo_wdata_reg <= bus_req.wdata;
			end
		end
	end

	// Read multiplexer; unmapped and reserved 02, 03, 05 read zero, reserved 04 reads its written byte
	always_comb begin
		rdata_next = ssm_pkg::BYTE_RESET;
		if (in_page) begin
			rdata_next = page_mem[page_sel][page_idx];
		end else if (in_band) begin
			rdata_next = band_mem[op_mode_reg[ssm_pkg::BAND_BIT]][band_idx];
		end else begin
			unique case (bus_req.addr)
				ssm_pkg::FIFO_PORT_ADDR: begin
					rdata_next = asleep ? ssm_pkg::BYTE_RESET : fifo_head;
				end
				ssm_pkg::OP_MODE_ADDR: rdata_next = op_mode_reg;
				ssm_pkg::RSVD_04_ADDR: rdata_next = rsvd_04_reg;
				ssm_pkg::FREQ_HIGH_ADDR: rdata_next = freq_high_reg;
				ssm_pkg::FREQ_MID_ADDR: rdata_next = freq_mid_reg;
				ssm_pkg::FREQ_LOW_ADDR: rdata_next = freq_low_reg;
				default: rdata_next = ssm_pkg::BYTE_RESET;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_reg <= ssm_pkg::BYTE_RESET;
		end else if (bus_req.rd) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= ssm_pkg::BYTE_RESET;
		end
	end

	// Outputs
	assign bus_rdata = rdata_reg;
	assign fifo_ctl = '{push: fifo_push_reg, pop: fifo_pop_reg, clear: fifo_clear_reg,
		wdata: fifo_wdata_reg};
	assign dev_state = ssm_pkg::ssm_state_t'(op_mode_reg[ssm_pkg::STATE_HI_BIT:0]);
	assign modem_family_select = op_mode_reg[ssm_pkg::FAMILY_BIT];
	assign band_bank_select = op_mode_reg[ssm_pkg::BAND_BIT];
	assign mode_trigger = mode_trig_reg;
	assign freq_trigger = freq_trig_reg;
	// word scaled downstream by crystal over two to the nineteenth
	assign carrier_word = {freq_high_reg, freq_mid_reg, freq_low_reg};

	// Checks

	a_family_locked: assert property (
		@(posedge clk) disable iff (rst)
		bus_req.wr && bus_req.addr == ssm_pkg::OP_MODE_ADDR && !asleep
		|=> $stable(modem_family_select))
		else $error("modem family changed outside sleep");

	a_fifo_closed: assert property (
		@(posedge clk) disable iff (rst)
		asleep && bus_req.addr == ssm_pkg::FIFO_PORT_ADDR && (bus_req.wr || bus_req.rd)
		|=> !fifo_ctl.push && !fifo_ctl.pop && fifo_ctl.clear && bus_rdata == 8'h00)
		else $error("fifo port reachable in sleep");

	a_fifo_push_data: assert property (
		@(posedge clk) disable iff (rst)
		bus_req.wr && bus_req.addr == ssm_pkg::FIFO_PORT_ADDR && !asleep
		|=> (fifo_ctl.push && fifo_ctl.wdata == $past(bus_req.wdata))
			##1 (!fifo_ctl.push
			|| $past(bus_req.wr && bus_req.addr == ssm_pkg::FIFO_PORT_ADDR)))
		else $error("fifo push missing or wrong");

	a_rsvd_zero: assert property (
		@(posedge clk) disable iff (rst)
		op_mode_reg[ssm_pkg::RSVD_HI_BIT:ssm_pkg::RSVD_LO_BIT] == 2'h0)
		else $error("reserved mode bits not zero");

	a_mode_trigger: assert property (
		@(posedge clk) disable iff (rst)
		bus_req.wr && bus_req.addr == ssm_pkg::OP_MODE_ADDR
		|=> mode_trigger && dev_state == $past(bus_req.wdata[2:0])
			&& band_bank_select == $past(bus_req.wdata[ssm_pkg::BAND_BIT]))
		else $error("state write not applied or not triggered");

	a_freq_trigger: assert property (
		@(posedge clk) disable iff (rst)
		bus_req.wr && bus_req.addr == ssm_pkg::FREQ_LOW_ADDR
		|=> freq_trigger && carrier_word[7:0] == $past(bus_req.wdata)
			&& carrier_word[23:8] == $past(carrier_word[23:8]))
		else $error("low carrier byte write not triggered");

	a_no_spurious_trig: assert property (
		@(posedge clk) disable iff (rst)
		freq_trigger |-> $past(bus_req.wr) && $past(bus_req.addr) == ssm_pkg::FREQ_LOW_ADDR)
		else $error("carrier trigger without low byte write");

	a_page_route: assert property (
		@(posedge clk) disable iff (rst)
		bus_req.rd && in_page
		|=> bus_rdata == $past(page_mem[page_sel][page_idx]))
		else $error("page read from wrong page");

	a_rsvd_read: assert property (
		@(posedge clk) disable iff (rst)
		bus_req.rd && (bus_req.addr == ssm_pkg::RSVD_02_ADDR
			|| bus_req.addr == ssm_pkg::RSVD_03_ADDR || bus_req.addr == ssm_pkg::RSVD_05_ADDR)
		|=> bus_rdata == 8'h00)
		else $error("reserved address read nonzero");

	a_band_keep: assert property (
		@(posedge clk) disable iff (rst)
		bus_req.wr && in_band
		|=> band_mem[!band_bank_select][$past(band_idx)]
			== $past(band_mem[!band_bank_select][band_idx]))
		else $error("band write leaked into other bank");

	a_family_sleep_only: assert property (
		@(posedge clk) disable iff (rst)
		$changed(modem_family_select)
		|-> $past(asleep && bus_req.wr && bus_req.addr == ssm_pkg::OP_MODE_ADDR))
		else $error("modem family changed without a write in sleep");

	a_state_write_only: assert property (
		@(posedge clk) disable iff (rst)
		$changed(dev_state) |-> $past(bus_req.wr && bus_req.addr == ssm_pkg::OP_MODE_ADDR))
		else $error("device state changed without a mode write");

	a_mode_trig_cause: assert property (
		@(posedge clk) disable iff (rst)
		mode_trigger |-> $past(bus_req.wr && bus_req.addr == ssm_pkg::OP_MODE_ADDR))
		else $error("mode trigger without mode write");

	a_carrier_write_only: assert property (
		@(posedge clk) disable iff (rst)
		$changed(carrier_word)
		|-> $past(bus_req.wr && (bus_req.addr == ssm_pkg::FREQ_HIGH_ADDR
			|| bus_req.addr == ssm_pkg::FREQ_MID_ADDR
			|| bus_req.addr == ssm_pkg::FREQ_LOW_ADDR)))
		else $error("carrier word changed without a carrier write");

	a_carrier_high_read: assert property (
		@(posedge clk) disable iff (rst)
		bus_req.rd && bus_req.addr == ssm_pkg::FREQ_HIGH_ADDR
		|=> bus_rdata == $past(carrier_word[23:16]))
		else $error("high carrier byte read wrong");

	a_carrier_mid_read: assert property (
		@(posedge clk) disable iff (rst)
		bus_req.rd && bus_req.addr == ssm_pkg::FREQ_MID_ADDR
		|=> bus_rdata == $past(carrier_word[15:8]))
		else $error("middle carrier byte read wrong");

	a_carrier_low_read: assert property (
		@(posedge clk) disable iff (rst)
		bus_req.rd && bus_req.addr == ssm_pkg::FREQ_LOW_ADDR
		|=> bus_rdata == $past(carrier_word[7:0]))
		else $error("low carrier byte read wrong");

	a_mode_read_fields: assert property (
		@(posedge clk) disable iff (rst)
		bus_req.rd && bus_req.addr == ssm_pkg::OP_MODE_ADDR
		|=> bus_rdata[ssm_pkg::RSVD_HI_BIT:ssm_pkg::RSVD_LO_BIT] == 2'h0
			&& bus_rdata[ssm_pkg::STATE_HI_BIT:0] == $past(dev_state)
			&& bus_rdata[ssm_pkg::FAMILY_BIT] == $past(modem_family_select)
			&& bus_rdata[ssm_pkg::BAND_BIT] == $past(band_bank_select))
		else $error("mode register read wrong");

	a_fifo_pop_data: assert property (
		@(posedge clk) disable iff (rst)
		bus_req.rd && bus_req.addr == ssm_pkg::FIFO_PORT_ADDR && !asleep
		|=> fifo_ctl.pop && bus_rdata == $past(fifo_head))
		else $error("fifo pop missing or wrong data");

	a_fifo_clear_sleep: assert property (
		@(posedge clk) disable iff (rst)
		dev_state == ssm_pkg::ST_SLEEP |=> fifo_ctl.clear)
		else $error("fifo not cleared in sleep");

	a_band_route: assert property (
		@(posedge clk) disable iff (rst)
		bus_req.rd && in_band
		|=> bus_rdata == $past(band_mem[band_bank_select][band_idx]))
		else $error("band read from wrong bank");

endmodule : ssm_regs

// ==== tb/ssm_host.sv ====
// Host controller model for the mode and carrier register bank.
// Assumes one-cycle strobes and read data exactly one cycle after the strobe.
`timescale 1ns/1ps

module ssm_host (
	// Clock
	input wire logic clk,
	// Register port
	output ssm_pkg::ssm_req_t bus_req,
	input wire logic [7:0] bus_rdata
);
	initial bus_req = '0;

	// Released address and data show the inverse, not the last value
	task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
		@(posedge clk);
		bus_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus_req <= '{addr: ~addr, wdata: ~data, wr: 1'b0, rd: 1'b0};
		#1;
	endtask : write_reg

	task automatic read_reg(input logic [6:0] addr, output logic [7:0] data);
		@(posedge clk);
		bus_req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus_req <= '{addr: ~addr, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
		#1;
		data = bus_rdata;
	endtask : read_reg
endmodule : ssm_host

// ==== tb/ssm_regs_tb.sv ====
// Self-checking bench for the mode and carrier register bank.
// Assumes the host model in ssm_host and a 125 MHz clock.
`timescale 1ns/1ps

module ssm_regs_tb;
	logic clk;
	logic rst;
	logic [7:0] fifo_head;
	logic [7:0] bus_rdata;
	ssm_pkg::ssm_req_t bus_req;
	ssm_pkg::ssm_fifo_t fifo_ctl;
	ssm_pkg::ssm_state_t dev_state;
	logic family;
	logic band;
	logic mode_trig;
	logic freq_trig;
	logic [23:0] carrier_word;
	int mismatches;
	int cmp_count;

	ssm_regs DUT (.clk(clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
		.fifo_ctl(fifo_ctl), .fifo_head(fifo_head), .dev_state(dev_state),
		.modem_family_select(family), .band_bank_select(band), .mode_trigger(mode_trig),
		.freq_trigger(freq_trig), .carrier_word(carrier_word));
	ssm_host host (.clk(clk), .bus_req(bus_req), .bus_rdata(bus_rdata));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic rd(input logic [6:0] addr, input logic [7:0] exp);
		logic [7:0] v;
		host.read_reg(addr, v);
		chk($sformatf("reg %h", addr), 24'(exp), 24'(v));
	endtask : rd

	task automatic wr(input logic [6:0] addr, input logic [7:0] data);
		host.write_reg(addr, data);
	endtask : wr

	task automatic t_reset;
		int mhz;
		rd(7'h01, 8'h09);
		rd(7'h06, 8'h6C);
		rd(7'h07, 8'h80);
		rd(7'h08, 8'h00);
		chk("carrier", 24'h6C8000, carrier_word);
		chk("band", 24'h1, 24'(band));
		chk("state", 24'h1, 24'(dev_state));
		chk("family", 24'h0, 24'(family));
		chk("clear", 24'h0, 24'(fifo_ctl.clear));
		mhz = int'(real'(carrier_word) * ssm_pkg::XTAL_MHZ / real'(1 << ssm_pkg::FREQ_SHIFT));
		chk("carrier mhz", 24'h1B2, 24'(mhz));
	endtask : t_reset

	task automatic t_carrier;
		wr(7'h06, 8'h12);
		chk("freq trig", 24'h0, 24'(freq_trig));
		wr(7'h07, 8'h34);
		wr(7'h08, 8'h56);
		chk("freq trig", 24'h1, 24'(freq_trig));
		chk("carrier", 24'h123456, carrier_word);
		@(posedge clk);
		#1;
		chk("freq trig", 24'h0, 24'(freq_trig));
		rd(7'h07, 8'h34);
	endtask : t_carrier

	task automatic t_family;
		wr(7'h01, 8'h81);
		chk("family", 24'h0, 24'(family));
		chk("mode trig", 24'h1, 24'(mode_trig));
		wr(7'h01, 8'h08);
		repeat (2) @(posedge clk);
		#1;
		chk("clear", 24'h1, 24'(fifo_ctl.clear));
		wr(7'h00, 8'h77);
		chk("push", 24'h0, 24'(fifo_ctl.push));
		rd(7'h00, 8'h00);
		chk("pop", 24'h0, 24'(fifo_ctl.pop));
		wr(7'h01, 8'hB8);
		chk("family", 24'h1, 24'(family));
		rd(7'h01, 8'h88);
	endtask : t_family

	task automatic t_states;
		for (int c = 0; c < 8; c++) begin
			wr(7'h01, 8'h88 | 8'(c));
			chk("state", 24'(c), 24'(dev_state));
			chk("mode trig", 24'h1, 24'(mode_trig));
		end
		wr(7'h01, 8'h89);
		wr(7'h01, 8'h09);
		chk("family", 24'h1, 24'(family));
	endtask : t_states

	task automatic t_fifo;
		logic [7:0] v;
		@(posedge clk);
		fifo_head <= 8'hC3;
		#1;
		chk("clear", 24'h0, 24'(fifo_ctl.clear));
		host.read_reg(7'h00, v);
		chk("fifo rd", 24'hC3, 24'(v));
		chk("pop", 24'h1, 24'(fifo_ctl.pop));
		wr(7'h00, 8'hA5);
		chk("push", 24'h1, 24'(fifo_ctl.push));
		chk("fifo wd", 24'hA5, 24'(fifo_ctl.wdata));
	endtask : t_fifo

	task automatic t_pages;
		wr(7'h20, 8'h11);
		wr(7'h01, 8'hC9);
		rd(7'h20, 8'h00);
		wr(7'h20, 8'h22);
		wr(7'h3F, 8'h5C);
		wr(7'h01, 8'h89);
		rd(7'h20, 8'h11);
		rd(7'h3F, 8'h00);
		wr(7'h01, 8'hC9);
		rd(7'h0D, 8'h00);
		rd(7'h3F, 8'h5C);
		wr(7'h01, 8'h89);
	endtask : t_pages

	task automatic t_band;
		wr(7'h61, 8'h33);
		wr(7'h73, 8'h44);
		wr(7'h01, 8'h81);
		chk("band", 24'h0, 24'(band));
		rd(7'h61, 8'h00);
		wr(7'h61, 8'h55);
		wr(7'h01, 8'h89);
		rd(7'h61, 8'h33);
		rd(7'h73, 8'h44);
		wr(7'h01, 8'h81);
		rd(7'h61, 8'h55);
	endtask : t_band

	task automatic t_reserved;
		for (int a = 2; a < 6; a++) begin
			wr(7'(a), 8'hFF);
		end
		wr(7'h40, 8'hAA);
		rd(7'h02, 8'h00);
		rd(7'h03, 8'h00);
		rd(7'h04, 8'hFF);
		@(posedge clk);
		#1;
		chk("rdata idle", 24'h0, 24'(bus_rdata));
		rd(7'h05, 8'h00);
		rd(7'h40, 8'h00);
	endtask : t_reserved

	task automatic report_and_stop;
		if (mismatches == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		rst = 1'b1;
		fifo_head = 8'h5A;
		mismatches = 0;
		cmp_count = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_carrier();
		t_family();
		t_states();
		t_fifo();
		t_pages();
		t_band();
		t_reserved();
		report_and_stop();
	end

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		report_and_stop();
	end
endmodule : ssm_regs_tb
